// file: vlt_defines.svh
// register indices, field positions, reset values and timing counts
`ifndef VLT_DEFINES_SVH
`define VLT_DEFINES_SVH

// register indices in the switch register space
`define VLT_IDX_CMD        16'h180b
`define VLT_IDX_WR_DATA    16'h180c
`define VLT_IDX_RD_DATA    16'h180e
`define VLT_IDX_CMD_STS    16'h1810

// command register fields
`define VLT_CMD_SEL_BIT    5
`define VLT_CMD_RNW_BIT    4
`define VLT_CMD_IDX_HI     3
`define VLT_CMD_IDX_LO     0

// data field layout
`define VLT_DATA_W         18
`define VLT_VID_HI         11
`define VLT_VID_LO         0
`define VLT_PRI_HI         14
`define VLT_PRI_LO         12
`define VLT_UNTAG_BASE     12
`define VLT_PDEF_W         15

// table sizes
`define VLT_VLAN_ENTRIES   16
`define VLT_PORTS          3

// reset values
`define VLT_RD_DATA_RST    18'h00000
`define VLT_ZERO32         32'h00000000

// cycles a table command stays pending
`define VLT_CMD_CYCLES     2'h2

`endif

// file: vlt_pkg.sv
// types shared by the vlan table read path
package vlt_pkg;

  typedef enum logic [1:0] {
    VLT_ST_IDLE = 2'b01,
    VLT_ST_BUSY = 2'b10
  } vlt_state_t;

  typedef logic [17:0] vlt_entry_t;
  typedef logic [14:0] vlt_pdef_t;
  typedef logic [1:0]  vlt_port_t;

endpackage : vlt_pkg

// file: vlt_lookup_if.sv
// tables and frame lookup signals between the register block and the classifier
`timescale 1ns/10ps
interface vlt_lookup_if;
  vlt_pkg::vlt_entry_t vlanTable [16];
  vlt_pkg::vlt_pdef_t  pdefTable [3];
  vlt_pkg::vlt_port_t  inPort;
  logic                inTagged;
  logic [11:0]         inVid;
  logic [2:0]          inPri;
  logic [2:0]          admitNonMember;
  logic [2:0]          egressHybrid;
  logic [11:0]         outVid;
  logic [2:0]          outPri;
  logic                outDrop;
  logic [2:0]          outEgress;
  logic [2:0]          outUntag;

  modport tables (output vlanTable, pdefTable, inPort, inTagged, inVid, inPri, admitNonMember,
                  egressHybrid, input outVid, outPri, outDrop, outEgress, outUntag);
  modport classify (input vlanTable, pdefTable, inPort, inTagged, inVid, inPri, admitNonMember,
                    egressHybrid, output outVid, outPri, outDrop, outEgress, outUntag);
endinterface : vlt_lookup_if

// file: vlt_frame_classify.sv
// per-frame vid resolution and vlan membership lookup
`include "vlt_defines.svh"
`timescale 1ns/10ps
module vlt_frame_classify (
  vlt_lookup_if.classify lk
);

  // ==========================================================
  // default vid and priority for untagged or null-vid frames
  // ==========================================================
  wire                useDefault = !lk.inTagged || (lk.inVid == 12'h000);  // see RQ4
  wire vlt_pkg::vlt_pdef_t pdef  = lk.pdefTable[lk.inPort];
  wire [11:0]         effVid     = useDefault ? pdef[`VLT_VID_HI:`VLT_VID_LO] : lk.inVid;  // see RQ4
  wire [2:0]          effPri     = useDefault ? pdef[`VLT_PRI_HI:`VLT_PRI_LO] : lk.inPri;  // see RQ4

  // ==========================================================
  // vlan table match
  // ==========================================================
  wire [`VLT_VLAN_ENTRIES-1:0] hitVec;
  genvar gi;
  generate
    for (gi = 0; gi < `VLT_VLAN_ENTRIES; gi++) begin : g_match
      // zero vid disables an entry
      assign hitVec[gi] = (lk.vlanTable[gi][`VLT_VID_HI:`VLT_VID_LO] == effVid) &&
                          (lk.vlanTable[gi][`VLT_VID_HI:`VLT_VID_LO] != 12'h000);
    end
  endgenerate

  function automatic vlt_pkg::vlt_entry_t pickEntry(input logic [`VLT_VLAN_ENTRIES-1:0] hits,
                                                    input vlt_pkg::vlt_entry_t tbl [16]);
    vlt_pkg::vlt_entry_t r;
    r = 18'h00000;
    for (int i = `VLT_VLAN_ENTRIES - 1; i >= 0; i--) begin
      if (hits[i]) begin
        r = tbl[i];
      end
    end
    return r;
  endfunction : pickEntry

  wire vlt_pkg::vlt_entry_t hitEntry = pickEntry(hitVec, lk.vlanTable);

  // ==========================================================
  // per-port member and untag bits
  // ==========================================================
  wire [2:0] memberBits;
  wire [2:0] untagBits;
  generate
    for (gi = 0; gi < `VLT_PORTS; gi++) begin : g_port
      assign memberBits[gi] = hitEntry[`VLT_UNTAG_BASE + 2*gi + 1];  // see RQ6 see RQ9 see RQ10
      assign untagBits[gi]  = hitEntry[`VLT_UNTAG_BASE + 2*gi];      // see RQ8 see RQ9 see RQ10
    end
  endgenerate

  wire inMember = memberBits[lk.inPort];
  wire inUntag  = untagBits[lk.inPort];

  assign lk.outVid    = effVid;
  assign lk.outPri    = effPri;
  assign lk.outDrop   = !inMember && !lk.admitNonMember[lk.inPort];     // see RQ7
  assign lk.outEgress = memberBits;                                     // see RQ6 see RQ7
  assign lk.outUntag  = inUntag ? lk.egressHybrid : 3'h0;               // see RQ8

endmodule : vlt_frame_classify

// file: vlt_read_data.sv
// vlan table read data register with command pacing and frame lookup
//
// Operation
// RQ1 - read-only register returns last selected entry
// RQ2 - port default mode: vid in 11:0
// RQ3 - port default mode: priority in 14:12
// RQ4 - untagged or null-vid frames take port defaults
// RQ5 - vlan mode: member, untag, vid returned
// RQ6 - member bit set admits and floods that port
// RQ7 - non-member drops unless admit-non-member, no flood
// RQ8 - untag bit strips tag on hybrid egress
// RQ9 - port 1 member bit 15, untag 14
// RQ10 - port 0 member bit 13, untag 12
// RQ11 - vlan mode: vid in bits 11:0
// RQ12 - pending set during command; read after clear
// RQ13 - software avoids zero and reserved vid
// RQ14 - reserved bits read zero, writes ignored
`include "vlt_defines.svh"
`timescale 1ns/10ps
module vlt_read_data (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic [15:0] regAddr,
  input  wire logic        regRead,
  input  wire logic        regWrite,
  input  wire logic [31:0] regWdata,
  output logic      [31:0] regRdata,
  input  wire logic [2:0]  admitNonMemberConfig,
  input  wire logic [2:0]  egressPortTypeConfig,
  input  wire logic        frameValid,
  input  wire logic [1:0]  framePort,
  input  wire logic        frameTagged,
  input  wire logic [11:0] frameVid,
  input  wire logic [2:0]  framePri,
  output logic             resultValid,
  output logic      [11:0] resultVid,
  output logic      [2:0]  resultPri,
  output logic             resultDrop,
  output logic      [2:0]  resultEgress,
  output logic      [2:0]  resultUntag
);

  // ==========================================================
  // storage
  // ==========================================================
  vlt_pkg::vlt_entry_t vlanTable_q [16];
  vlt_pkg::vlt_pdef_t  pdefTable_q [3];
  logic [17:0]         writeData_q;
  logic [17:0]         readData_q;
  logic [5:0]          cmd_q;
  logic [1:0]          busyCnt_q;
  vlt_pkg::vlt_state_t state_q;
  vlt_pkg::vlt_state_t state_d;

  // ==========================================================
  // helpers
  // ==========================================================
  function automatic logic idxHit(input logic [15:0] addr, input logic [15:0] idx);
    return (addr == idx);
  endfunction : idxHit

  // ==========================================================
  // register decode
  // ==========================================================
  wire       hitCmd    = idxHit(regAddr, `VLT_IDX_CMD);
  wire       hitWrData = idxHit(regAddr, `VLT_IDX_WR_DATA);
  wire       hitRdData = idxHit(regAddr, `VLT_IDX_RD_DATA);
  wire       hitSts    = idxHit(regAddr, `VLT_IDX_CMD_STS);
  wire       pending   = (state_q == vlt_pkg::VLT_ST_BUSY);
  // a command written while one is pending is dropped
  wire       startCmd  = regWrite && hitCmd && !pending;              // see RQ12

  // ==========================================================
  // command fields and pacing
  // ==========================================================
  wire       cmdSel    = cmd_q[`VLT_CMD_SEL_BIT];
  wire       cmdRnw    = cmd_q[`VLT_CMD_RNW_BIT];
  wire [3:0] cmdIdx    = cmd_q[`VLT_CMD_IDX_HI:`VLT_CMD_IDX_LO];
  wire       cmdDone   = pending && (busyCnt_q == 2'h1);
  // counts down the pending window
  wire [1:0] busyCnt_d = startCmd ? `VLT_CMD_CYCLES : (pending ? busyCnt_q - 2'h1 : 2'h0);  // see RQ12
  wire       pdefOk    = (cmdIdx < 4'h3);
  wire [1:0] pdefIdx   = cmdIdx[1:0];

  // port default entry: reserved 17:15 read as zero
  wire [17:0] pdefWord = pdefOk ? {3'h0, pdefTable_q[pdefIdx]} : 18'h00000;  // see RQ2 see RQ3
  // vlan entry keeps member, untag and vid in place
  wire [17:0] vlanWord = vlanTable_q[cmdIdx];                                // see RQ5 see RQ11
  wire [17:0] tblWord  = cmdSel ? pdefWord : vlanWord;                        // see RQ1

  // ==========================================================
  // register read mux
  // ==========================================================
  wire [31:0] rdMux = hitRdData ? {14'h0000, readData_q} :                    // see RQ14
                      hitSts    ? {31'h00000000, pending} :                   // see RQ12
                      hitCmd    ? {26'h0000000, cmd_q} :
                      hitWrData ? {14'h0000, writeData_q} : `VLT_ZERO32;

  // ==========================================================
  // command sequencer
  // ==========================================================
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      vlt_pkg::VLT_ST_IDLE: begin
        if (startCmd) begin
          state_d = vlt_pkg::VLT_ST_BUSY;
        end
      end
      vlt_pkg::VLT_ST_BUSY: begin
        if (cmdDone) begin
          state_d = vlt_pkg::VLT_ST_IDLE;                         // see RQ12
        end
      end
      default: state_d = vlt_pkg::VLT_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q   <= vlt_pkg::VLT_ST_IDLE;
      busyCnt_q <= 2'h0;
    end else begin
      state_q   <= state_d;
      busyCnt_q <= busyCnt_d;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cmd_q       <= 6'h00;
      writeData_q <= 18'h00000;
    end else begin
      if (startCmd) begin
        cmd_q <= regWdata[5:0];
      end
      if (regWrite && hitWrData) begin
        writeData_q <= regWdata[17:0];
      end
    end
  end

  // ==========================================================
  // read data capture and table writes
  // ==========================================================
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      readData_q <= `VLT_RD_DATA_RST;
    end else if (cmdDone && cmdRnw) begin
      readData_q <= tblWord;                                      // see RQ1
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < `VLT_VLAN_ENTRIES; i++) begin
        vlanTable_q[i] <= 18'h00000;
      end
      for (int i = 0; i < `VLT_PORTS; i++) begin
        pdefTable_q[i] <= 15'h0000;
      end
    end else if (cmdDone && !cmdRnw) begin
      if (cmdSel) begin
        if (pdefOk) begin
          pdefTable_q[pdefIdx] <= writeData_q[`VLT_PDEF_W-1:0];
        end
      end else begin
        vlanTable_q[cmdIdx] <= writeData_q;
      end
    end
  end

  // ==========================================================
  // register read port
  // ==========================================================
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      regRdata <= `VLT_ZERO32;
    end else if (regRead) begin
      regRdata <= rdMux;
    end
  end

  // ==========================================================
  // frame lookup
  // ==========================================================
  vlt_lookup_if lk ();

  assign lk.vlanTable      = vlanTable_q;
  assign lk.pdefTable      = pdefTable_q;
  assign lk.inPort         = framePort;
  assign lk.inTagged       = frameTagged;
  assign lk.inVid          = frameVid;
  assign lk.inPri          = framePri;
  assign lk.admitNonMember = admitNonMemberConfig;
  assign lk.egressHybrid   = egressPortTypeConfig;

  vlt_frame_classify u_classify (
    .lk (lk.classify)
  );

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      resultValid  <= 1'b0;
      resultVid    <= 12'h000;
      resultPri    <= 3'h0;
      resultDrop   <= 1'b0;
      resultEgress <= 3'h0;
      resultUntag  <= 3'h0;
    end else begin
      resultValid  <= frameValid;
      if (frameValid) begin
        resultVid    <= lk.outVid;                               // see RQ4
        resultPri    <= lk.outPri;                               // see RQ4
        resultDrop   <= lk.outDrop;                              // see RQ7
        resultEgress <= lk.outEgress;                            // see RQ6
        resultUntag  <= lk.outUntag;                             // see RQ8
      end
    end
  end

endmodule : vlt_read_data

// file: vlt_read_data_properties.sv
// assertions on the vlan table read data block ports
`timescale 1ns/10ps
module vlt_read_data_properties (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic [15:0] regAddr,
  input wire logic        regRead,
  input wire logic        regWrite,
  input wire logic [31:0] regRdata,
  input wire logic [2:0]  admitNonMemberConfig,
  input wire logic [2:0]  egressPortTypeConfig,
  input wire logic        frameValid,
  input wire logic [1:0]  framePort,
  input wire logic        frameTagged,
  input wire logic [11:0] frameVid,
  input wire logic        resultValid,
  input wire logic [11:0] resultVid,
  input wire logic        resultDrop,
  input wire logic [2:0]  resultEgress,
  input wire logic [2:0]  resultUntag
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ==========
  // register read path
  rsv_zero_a: assert property (regRdata[31:18] == 14'h0000)
    else $error("reserved read bits set");
  rdata_hold_a: assert property (!$past(regRead) |-> $stable(regRdata))
    else $error("read data moved without a read");
  unmapped_zero_a: assert property (regRead && regAddr == 16'h1234 |=> regRdata == 32'h00000000)
    else $error("unmapped read not zero");
  pend_set_a: assert property ((regWrite && regAddr == 16'h180b) ##2
    (regRead && regAddr == 16'h1810) |=> regRdata[0]) else $error("pending not set");
  pend_clear_a: assert property ((regWrite && regAddr == 16'h180b) ##4
    (regRead && regAddr == 16'h1810) |=> !regRdata[0]) else $error("pending not cleared");
  // ==========
  // frame lookup
  result_cause_a: assert property (resultValid |-> $past(frameValid))
    else $error("result without request");
  tag_keep_a: assert property (resultValid && $past(frameTagged) && $past(frameVid) != 12'h000
    |-> resultVid == $past(frameVid)) else $error("tagged vid changed");
  member_pass_a: assert property (resultValid && resultEgress[$past(framePort)] |-> !resultDrop)
    else $error("member frame dropped");
  nonmember_drop_a: assert property (resultValid && !resultEgress[$past(framePort)]
    |-> resultDrop == !$past(admitNonMemberConfig[framePort])) else $error("non-member drop wrong");
  untag_hybrid_a: assert property (resultValid |-> (resultUntag & ~$past(egressPortTypeConfig)) == 3'b000)
    else $error("untag on non-hybrid port");
endmodule : vlt_read_data_properties

// file: tb_top.sv
// self-checking bench for the vlan table read data block
`timescale 1ns/10ps
module tb_top;
  logic        clk, sys_rst, regRead, regWrite, frameValid, frameTagged;
  logic [15:0] regAddr;
  logic [31:0] regWdata, regRdata, rdVal, frRes;
  logic [2:0]  admitNonMemberConfig, egressPortTypeConfig, framePri, resultPri, resultEgress, resultUntag;
  logic [1:0]  framePort;
  logic [11:0] frameVid, resultVid;
  logic        resultValid, resultDrop;
  int          n_fail, compares;
  wire  [31:0] res = {9'h000, resultValid, resultDrop, resultEgress, resultUntag, resultPri, resultVid};

  vlt_read_data u_vlt_read_data (.clk, .sys_rst, .regAddr, .regRead, .regWrite, .regWdata, .regRdata,
    .admitNonMemberConfig, .egressPortTypeConfig, .frameValid, .framePort, .frameTagged, .frameVid,
    .framePri, .resultValid, .resultVid, .resultPri, .resultDrop, .resultEgress, .resultUntag);

  // ==========
  // helpers
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic summarize;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : summarize

  // one register access, two cycles; read data lands in rdVal
  task automatic op(input logic r, input logic [15:0] a, input logic [31:0] d);
    regRead = r;
    regWrite = !r;
    regAddr = a;
    regWdata = d;
    @(negedge clk);
    regRead = 1'b0;
    regWrite = 1'b0;
    @(negedge clk);
    rdVal = regRdata;
  endtask : op

  // command write, then bounded poll of pending
  task automatic cmd(input logic [5:0] c);
    op(1'b0, 16'h180b, {26'h0, c});
    for (int i = 0; i < 8; i++) begin
      op(1'b1, 16'h1810, 32'h0);
      if (rdVal[0] === 1'b0) return;
    end
    n_fail++;
    summarize();
  endtask : cmd

  task automatic frm(input logic [1:0] p, input logic t, input logic [11:0] v);
    framePort = p;
    frameTagged = t;
    frameVid = v;
    framePri = 3'h2;
    frameValid = 1'b1;
    @(negedge clk);
    frameValid = 1'b0;
    frRes = res;
    @(negedge clk);
  endtask : frm

  // ==========
  // scenarios
  task automatic s_reset;
    op(1'b1, 16'h180e, 32'h0);
    chk("rd_reset", rdVal, 32'h00000000);
    op(1'b1, 16'h1234, 32'h0);
    chk("unmapped", rdVal, 32'h00000000);
  endtask : s_reset

  task automatic s_vlan;
    op(1'b0, 16'h180c, 32'hfffb8123);
    cmd(6'h00);
    op(1'b0, 16'h180c, 32'h000070a5);
    cmd(6'h01);
    cmd(6'h10);
    op(1'b0, 16'h180e, 32'hffffffff);
    op(1'b1, 16'h180e, 32'h0);
    chk("vlan0", rdVal, 32'h00038123);
    cmd(6'h11);
    op(1'b1, 16'h180e, 32'h0);
    chk("vlan1", rdVal, 32'h000070a5);
  endtask : s_vlan

  task automatic s_pdef;
    op(1'b0, 16'h180c, 32'h0003dabc);
    cmd(6'h22);
    cmd(6'h32);
    op(1'b1, 16'h180e, 32'h0);
    chk("pdef", rdVal, 32'h00005abc);
    op(1'b1, 16'h180b, 32'h0);
    chk("cmdreg", rdVal, 32'h00000032);
    op(1'b1, 16'h180c, 32'h0);
    chk("wrdata", rdVal, 32'h0003dabc);
    cmd(6'h33);
    op(1'b1, 16'h180e, 32'h0);
    chk("pdef_none", rdVal, 32'h00000000);
  endtask : s_pdef

  task automatic s_frame;
    egressPortTypeConfig = 3'b010;
    frm(2'd2, 1'b0, 12'h777);
    chk("untagged", frRes, {9'h0, 2'b11, 6'o00, 3'h5, 12'habc});
    frm(2'd2, 1'b1, 12'h000);
    chk("nullvid", frRes, {9'h0, 2'b11, 6'o00, 3'h5, 12'habc});
    frm(2'd2, 1'b1, 12'h123);
    chk("member", frRes, {9'h0, 2'b10, 6'o62, 3'h2, 12'h123});
    frm(2'd0, 1'b1, 12'h123);
    chk("nonmember", frRes, {9'h0, 2'b11, 6'o60, 3'h2, 12'h123});
    admitNonMemberConfig = 3'b001;
    frm(2'd0, 1'b1, 12'h123);
    chk("admit", frRes, {9'h0, 2'b10, 6'o60, 3'h2, 12'h123});
  endtask : s_frame

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial begin
    sys_rst = 1'b1;
    regRead = 1'b0;
    regWrite = 1'b0;
    regAddr = 16'h0000;
    regWdata = 32'h00000000;
    admitNonMemberConfig = 3'b000;
    egressPortTypeConfig = 3'b000;
    frameValid = 1'b0;
    framePort = 2'd0;
    frameTagged = 1'b0;
    frameVid = 12'h000;
    framePri = 3'h0;
    repeat (16) @(posedge clk);
    @(negedge clk);
    sys_rst = 1'b0;
    @(negedge clk);
    s_reset();
    s_vlan();
    s_pdef();
    s_frame();
    summarize();
  end
endmodule : tb_top

bind vlt_read_data vlt_read_data_properties u_vlt_read_data_properties (.clk, .sys_rst, .regAddr,
  .regRead, .regWrite, .regRdata, .admitNonMemberConfig, .egressPortTypeConfig, .frameValid, .framePort,
  .frameTagged, .frameVid, .resultValid, .resultVid, .resultDrop, .resultEgress, .resultUntag);
